// *** rtl/uifc_ctrl.sv ***
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module uifc_ctrl #(
  parameter int FIFO_DEPTH = 64
) (
  // Clock and reset.
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Datapath state and events.
  input  wire uifc_pkg::uifc_events_t evt,
  input  wire logic [6:0]           rx_level,
  input  wire logic [6:0]           tx_level,
  input  wire logic                 enhanced_enable,
  input  wire logic                 rts_out_n,
  // Pin from outside the clock domain.
  input  wire logic                 cts_pin_n,
  // Control outputs.
  output logic                      irq,
  output logic                      sleep_mode,
  output logic                      rx_fifo_reset,
  output logic                      tx_fifo_reset,
  output logic                      fifo_enable,
  output logic                      dma_mode,
  output logic                      transmit_ready_pin_n,
  output logic                      receive_ready_pin_n
);

  // Maps a two-bit transmit selection to a count of free spaces.
  // The upper selections only land when enhanced mode allowed the write.
  // Used by both the interrupt condition and the refill tracker.
  function automatic logic [6:0] tx_trig(input logic [1:0] s);
    case (s)
      2'h0:    tx_trig = uifc_pkg::TX_TRIG_0;
      2'h1:    tx_trig = uifc_pkg::TX_TRIG_1;
      2'h2:    tx_trig = uifc_pkg::TX_TRIG_2;
      default: tx_trig = uifc_pkg::TX_TRIG_3;
    endcase
  endfunction : tx_trig

  // Maps a two-bit receive selection to a count of characters.
  // Shared by the receive interrupt and the DMA receive pin.
  // Keeping one decoder stops the two from disagreeing.
  function automatic logic [6:0] rx_trig(input logic [1:0] s);
    case (s)
      2'h0:    rx_trig = uifc_pkg::RX_TRIG_0;
      2'h1:    rx_trig = uifc_pkg::RX_TRIG_1;
      2'h2:    rx_trig = uifc_pkg::RX_TRIG_2;
      default: rx_trig = uifc_pkg::RX_TRIG_3;
    endcase
  endfunction : rx_trig

  logic [7:0] interrupt_enable;   // Interrupt enable register.
  logic [7:0] fifo_control;       // Stored FIFO control without reset bits.
  logic [2:0] cts_sync;           // Pin synchroniser chain.
  logic       cts_stable;         // Filtered pin level.
  logic       rts_prev;           // Previous flow output level.
  logic       tx_flag;            // Sticky transmit ready.
  logic       timeout_flag;       // Sticky receive timeout.
  logic       xoff_flag;          // Xoff pending.
  logic       special_flag;       // Special character pending.
  logic       flow_flag;          // Flow pin change pending.
  logic       tx_above;           // Free space fell to trigger or below.
  logic [5:0] code;               // Current source code.
  logic       any_pending;        // Any enabled source pending.
  logic       tx_cond;            // Any cause of transmit ready.
  logic       tx_raw_prev;        // Transmit cause one cycle ago.

  // Bus decode strobes and combinational source terms.
  // Accesses are decoded in the cycle in which pready is high,
  // so a write lands once and a read side effect fires once.
  logic       wr_access;
  logic       rd_access;
  logic [6:0] tx_space;
  logic [6:0] next_tx_space;
  logic       line_src;
  logic       rx_src;
  logic       modem_src;
  logic       tx_src_raw;
  logic       status_read;
  logic       ie_write;
  logic       fc_write;

  assign wr_access   = psel && penable && pwrite && pready;
  assign rd_access   = psel && penable && !pwrite && pready;
  assign status_read = rd_access && (paddr == uifc_pkg::ADDR_INTERRUPT_STATUS);
  assign ie_write    = wr_access && (paddr == uifc_pkg::ADDR_INTERRUPT_ENABLE);
  assign fc_write    = wr_access && (paddr == uifc_pkg::ADDR_FIFO_CONTROL);
  assign tx_space    = 7'(FIFO_DEPTH) - tx_level;

  // Line status: error bits, held while errored characters remain.
  // This is a level source, so it drops only when the datapath clears
  // the error bits after the last errored character leaves.
  assign line_src = interrupt_enable[uifc_pkg::IE_LINE] &&
                    (|{evt.line_status[7], evt.line_status[4:1]});
  // Receive ready holds while level is at or above trigger.
  // Without FIFOs a single character is enough to request service.
  // Reads that bring the level below trigger drop the request.
  assign rx_src = interrupt_enable[uifc_pkg::IE_RX_READY] &&
                  (fifo_enable ? (rx_level >= rx_trig(fifo_control[7:6]))
                               : (rx_level != 7'h00));
  // Modem status change bits.
  // The datapath clears them when the modem status register is read.
  assign modem_src = interrupt_enable[uifc_pkg::IE_MODEM] && (|evt.modem_delta);
  // Raw transmit condition.
  // Free space above trigger, or an empty FIFO that was never refilled
  // past trigger; without FIFOs an empty holding register is enough.
  assign tx_src_raw = fifo_enable
      ? ((tx_space > tx_trig(fifo_control[5:4])) || (tx_level == 7'h00 && !tx_above))
      : (tx_level == 7'h00);
  // Automatic direction mode also reports an idle transmitter.
  assign tx_cond = tx_src_raw || (evt.rs485_auto && evt.tx_shift_empty);

  // Single cycle ready; one wait-free APB slave.
  // Ready rises in the access cycle that follows every setup cycle
  // and falls again at the next edge, so no transfer is stretched.
  // Read data is latched in the same setup cycle below.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Interrupt enable register, upper half gated by enhanced mode.
  // The lower four enables are always writable.
  // A write without enhanced mode leaves the upper four untouched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable <= uifc_pkg::RESET_INTERRUPT_ENABLE;
    end else if (ie_write) begin
      interrupt_enable[3:0] <= pwdata[3:0];
      if (enhanced_enable) begin
        interrupt_enable[7:4] <= pwdata[7:4];
      end
    end
  end

  // FIFO control: bit 0 must be set for other bits to apply.
  // The reset bits are never stored: they leave as one-cycle pulses
  // and the register reads back as zero, so nothing needs clearing.
  // The transmit trigger field also needs enhanced mode to change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_control  <= uifc_pkg::RESET_FIFO_CONTROL;
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
    end else begin
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
      if (fc_write) begin
        fifo_control[uifc_pkg::FC_ENABLE] <= pwdata[uifc_pkg::FC_ENABLE];
        if (pwdata[uifc_pkg::FC_ENABLE]) begin
          rx_fifo_reset <= pwdata[uifc_pkg::FC_RX_RESET];
          tx_fifo_reset <= pwdata[uifc_pkg::FC_TX_RESET];
          fifo_control[uifc_pkg::FC_DMA] <= pwdata[uifc_pkg::FC_DMA];
          fifo_control[7:6] <= pwdata[7:6];
          if (enhanced_enable) begin
            fifo_control[5:4] <= pwdata[5:4];
          end
        end
      end
    end
  end

  // Mirrors of control bits.
  // Each output comes from its own flop, one cycle behind the register,
  // which keeps the top-level outputs free of decode logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_enable <= 1'b0;
      dma_mode    <= 1'b0;
      sleep_mode  <= 1'b0;
    end else begin
      fifo_enable <= fifo_control[uifc_pkg::FC_ENABLE];
      dma_mode    <= fifo_control[uifc_pkg::FC_DMA];
      sleep_mode  <= interrupt_enable[uifc_pkg::IE_SLEEP];
    end
  end

  // DMA pins: mode 0 per character, mode 1 per trigger or space.
  // Both pins are active low. In normal mode receive asserts with any
  // character and transmit while the FIFO is empty; in DMA mode receive
  // waits for the trigger and transmit holds until the FIFO is full.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_ready_pin_n  <= 1'b1;
      transmit_ready_pin_n <= 1'b0;
    end else if (dma_mode) begin
      receive_ready_pin_n  <= !(rx_level >= rx_trig(fifo_control[7:6]));
      transmit_ready_pin_n <= (tx_level == 7'(FIFO_DEPTH));
    end else begin
      receive_ready_pin_n  <= (rx_level == 7'h00);
      transmit_ready_pin_n <= (tx_level != 7'h00);
    end
  end

  // Remembers the transmit cause, so that a cause that persists after a
  // clear does not set the flag again; only its rising edge counts.
  // Reset to one so that an idle transmitter gives no false edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_raw_prev <= 1'b1;
    end else begin
      tx_raw_prev <= tx_cond;
    end
  end

  // Tracks whether the last refill brought free space down to trigger or below.
  // Cleared when the FIFO runs empty, ready for the next refill.
  assign next_tx_space = tx_space;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_above <= 1'b0;
    end else if (tx_level == 7'h00) begin
      tx_above <= 1'b0;
    end else if (next_tx_space <= tx_trig(fifo_control[5:4])) begin
      tx_above <= 1'b1;
    end
  end

  // Transmit ready flag: set wins over clear.
  // A new cause, or enabling the source while the holding side is empty,
  // sets it; a status read or a transmit holding write clears it.
  // The flag still sets and clears while the source is disabled; only the encoder masks it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_flag <= 1'b0;
    end else if ((tx_cond && !tx_raw_prev) ||
                 (ie_write && pwdata[uifc_pkg::IE_TX_READY] &&
                  !interrupt_enable[uifc_pkg::IE_TX_READY] && tx_level == 7'h00)) begin
      tx_flag <= 1'b1;
    end else if (status_read || evt.tx_write) begin
      tx_flag <= 1'b0;
    end
  end

  // Receive timeout flag: a receive data read clears it.
  // The timer itself lives in the datapath and sends one pulse.
  // An expiry in the same cycle as a read keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= 1'b0;
    end else if (evt.timeout) begin
      timeout_flag <= 1'b1;
    end else if (evt.rx_read) begin
      timeout_flag <= 1'b0;
    end
  end

  // Xoff and special character flags.
  // Both need enhanced mode and the Xoff enable to be set at all.
  // Xon clears the Xoff case; a status read that reports this source
  // clears the special case, and a new match in that cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xoff_flag    <= 1'b0;
      special_flag <= 1'b0;
    end else begin
      if (evt.xoff_seen && enhanced_enable && interrupt_enable[uifc_pkg::IE_XOFF]) begin
        xoff_flag <= 1'b1;
      end else if (evt.xon_seen) begin
        xoff_flag <= 1'b0;
      end
      if (evt.special_seen && enhanced_enable && interrupt_enable[uifc_pkg::IE_XOFF]) begin
        special_flag <= 1'b1;
      end else if (status_read && code == uifc_pkg::CODE_XOFF) begin
        special_flag <= 1'b0;
      end
    end
  end

  // Clear-to-send pin: three flops, change counts when last two agree.
  // The first flop may go metastable and is read by nothing but the
  // second; the filtered level moves only on agreement of the last two.
  // The flow output is on this clock and needs only an edge register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_sync   <= 3'h7;
      cts_stable <= 1'b1;
      rts_prev   <= 1'b1;
    end else begin
      cts_sync <= {cts_sync[1:0], cts_pin_n};
      if (cts_sync[2] == cts_sync[1]) begin
        cts_stable <= cts_sync[2];
      end
      rts_prev <= rts_out_n;
    end
  end

  // Flow pin change flag: rising edges, or datapath deassert pulse.
  // Only available in enhanced mode; a modem status read clears it.
  // A new edge in the cycle of that read keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_flag <= 1'b0;
    end else if (enhanced_enable &&
                 ((interrupt_enable[uifc_pkg::IE_RTS] && rts_out_n && !rts_prev) ||
                  (interrupt_enable[uifc_pkg::IE_CTS] && cts_sync[1] &&
                   cts_sync[2] && !cts_stable) ||
                  evt.flow_deassert)) begin
      flow_flag <= 1'b1;
    end else if (evt.modem_read) begin
      flow_flag <= 1'b0;
    end
  end

  // Priority encoder of pending sources.
  // The first true term wins, so lower sources stay queued until the one above
  // them has been serviced, except the transmit flag, which any status read clears.
  // Timeout and receive ready share the receive enable bit.
  always_comb begin
    any_pending = 1'b1;
    if (line_src) begin
      code = uifc_pkg::CODE_LINE;
    end else if (timeout_flag && interrupt_enable[uifc_pkg::IE_RX_READY]) begin
      code = uifc_pkg::CODE_TIMEOUT;
    end else if (rx_src) begin
      code = uifc_pkg::CODE_RX;
    end else if (tx_flag && interrupt_enable[uifc_pkg::IE_TX_READY]) begin
      code = uifc_pkg::CODE_TX;
    end else if (modem_src) begin
      code = uifc_pkg::CODE_MODEM;
    end else if (xoff_flag || special_flag) begin
      code = uifc_pkg::CODE_XOFF;
    end else if (flow_flag) begin
      code = uifc_pkg::CODE_FLOW;
    end else begin
      code        = uifc_pkg::CODE_NONE;
      any_pending = 1'b0;
    end
  end

  // Interrupt request output.
  // Registered so the pin comes straight from a flop, one cycle late.
  // It falls once the last enabled source has been serviced.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= any_pending;
    end
  end

  // Read data: status reports only the top source.
  // Data is latched in the setup cycle and held through the access.
  // Unmapped offsets return zero with an error response.
  // The FIFO control register is write-only and reads as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      case (paddr)
        uifc_pkg::ADDR_INTERRUPT_ENABLE: prdata[7:0] <= interrupt_enable;
        uifc_pkg::ADDR_INTERRUPT_STATUS:
          prdata[7:0] <= {{2{fifo_control[uifc_pkg::FC_ENABLE]}}, code};
        uifc_pkg::ADDR_FIFO_CONTROL: prdata[7:0] <= 8'h00;
        uifc_pkg::ADDR_CORE_STATUS:
          prdata[7:0] <= {1'b0, flow_flag, special_flag, xoff_flag,
                          timeout_flag, tx_flag, tx_above, cts_stable};
        default: pslverr <= 1'b1;
      endcase
    end
  end

endmodule : uifc_ctrl

// *** rtl/uifc_pkg.sv ***
package uifc_pkg;

  // Register byte addresses on the bus.
  localparam logic [11:0] ADDR_INTERRUPT_ENABLE = 12'h000;
  localparam logic [11:0] ADDR_INTERRUPT_STATUS = 12'h004;
  localparam logic [11:0] ADDR_FIFO_CONTROL     = 12'h008;
  localparam logic [11:0] ADDR_CORE_STATUS      = 12'h00C;

  // Interrupt enable field positions.
  localparam int IE_RX_READY  = 0;
  localparam int IE_TX_READY  = 1;
  localparam int IE_LINE      = 2;
  localparam int IE_MODEM     = 3;
  localparam int IE_SLEEP     = 4;
  localparam int IE_XOFF      = 5;
  localparam int IE_RTS       = 6;
  localparam int IE_CTS       = 7;

  // FIFO control field positions.
  localparam int FC_ENABLE    = 0;
  localparam int FC_RX_RESET  = 1;
  localparam int FC_TX_RESET  = 2;
  localparam int FC_DMA       = 3;
  localparam int FC_TX_TRIG   = 4;
  localparam int FC_RX_TRIG   = 6;

  // Reset values.
  localparam logic [7:0] RESET_INTERRUPT_ENABLE = 8'h00;
  localparam logic [7:0] RESET_FIFO_CONTROL     = 8'h00;

  // Interrupt source codes, priority 1 first.
  localparam logic [5:0] CODE_LINE    = 6'h06;
  localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
  localparam logic [5:0] CODE_RX      = 6'h04;
  localparam logic [5:0] CODE_TX      = 6'h02;
  localparam logic [5:0] CODE_MODEM   = 6'h00;
  localparam logic [5:0] CODE_XOFF    = 6'h10;
  localparam logic [5:0] CODE_FLOW    = 6'h20;
  localparam logic [5:0] CODE_NONE    = 6'h01;

  // Trigger levels.
  localparam logic [6:0] TX_TRIG_0 = 7'h08;
  localparam logic [6:0] TX_TRIG_1 = 7'h10;
  localparam logic [6:0] TX_TRIG_2 = 7'h20;
  localparam logic [6:0] TX_TRIG_3 = 7'h38;
  localparam logic [6:0] RX_TRIG_0 = 7'h08;
  localparam logic [6:0] RX_TRIG_1 = 7'h10;
  localparam logic [6:0] RX_TRIG_2 = 7'h38;
  localparam logic [6:0] RX_TRIG_3 = 7'h3C;

  // Events from the serial datapath, one cycle pulses unless stated.
  typedef struct packed {
    logic [7:0] line_status;     // Level: line status bits.
    logic [3:0] modem_delta;     // Level: modem status change bits.
    logic       timeout;         // Pulse: receive timer expired.
    logic       xoff_seen;       // Pulse: Xoff character matched.
    logic       xon_seen;        // Pulse: Xon character matched.
    logic       special_seen;    // Pulse: special character matched.
    logic       flow_deassert;   // Pulse: auto flow pin deasserted.
    logic       rx_read;         // Pulse: receive holding read.
    logic       tx_write;        // Pulse: transmit holding written.
    logic       modem_read;      // Pulse: modem status read.
    logic       tx_shift_empty;  // Level: transmitter fully idle.
    logic       rs485_auto;      // Level: automatic direction mode.
  } uifc_events_t;

endpackage : uifc_pkg

// *** testbench/uifc_ctrl_properties.sv ***
`timescale 1ns/1ps
// Port checker for the interrupt and FIFO control block.
module uifc_ctrl_properties #(
  parameter int FIFO_DEPTH = 64
) (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB signals.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Control side.
  input wire logic        enhanced_enable,
  input wire logic        sleep_mode,
  input wire logic        rx_fifo_reset,
  input wire logic        tx_fifo_reset,
  input wire logic        fifo_enable,
  input wire logic        dma_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted writes and status reads, decoded once.
  logic fc_wr;
  logic ie_wr;
  logic st_rd;
  assign fc_wr = psel && penable && pready && pwrite && paddr == uifc_pkg::ADDR_FIFO_CONTROL;
  assign ie_wr = psel && penable && pready && pwrite && paddr == uifc_pkg::ADDR_INTERRUPT_ENABLE;
  assign st_rd = psel && penable && !pwrite && paddr == uifc_pkg::ADDR_INTERRUPT_STATUS;
  a_zero_wait: assert property (psel && !penable |=> pready)
    else $error("Ready missing in access cycle.");
  a_ready_once: assert property (pready |-> psel && penable ##1 !pready)
    else $error("Ready outside a single access cycle.");
  a_unmapped_err: assert property (psel && penable && paddr > uifc_pkg::ADDR_CORE_STATUS
                                   |-> pslverr)
    else $error("Unmapped access not refused.");
  // Mirrors follow the register one cycle later, so they are seen two edges on.
  a_fifo_enable: assert property (fc_wr |=> ##1 fifo_enable == $past(pwdata[0], 2))
    else $error("FIFO enable does not follow bit 0.");
  a_dma_gate: assert property (fc_wr && !pwdata[0] |=> ##1 $stable(dma_mode))
    else $error("DMA mode changed without bit 0.");
  a_dma_select: assert property (fc_wr && pwdata[0] |=>
                                 ##1 dma_mode == $past(pwdata[3], 2))
    else $error("DMA mode does not follow bit 3.");
  a_rx_reset: assert property (fc_wr && pwdata[0] && pwdata[1] |=>
                               rx_fifo_reset ##1 !rx_fifo_reset)
    else $error("Receive reset is not a single pulse.");
  a_tx_reset: assert property (fc_wr && pwdata[0] && pwdata[2] |=>
                               tx_fifo_reset ##1 !tx_fifo_reset)
    else $error("Transmit reset is not a single pulse.");
  a_reset_gate: assert property (fc_wr && !pwdata[0] |=>
                                 !rx_fifo_reset && !tx_fifo_reset)
    else $error("FIFO reset without bit 0.");
  a_sleep_gate: assert property (ie_wr && !enhanced_enable |=> ##1 $stable(sleep_mode))
    else $error("Sleep changed without enhanced enable.");
  a_sleep_set: assert property (ie_wr && enhanced_enable |=>
                                ##1 sleep_mode == $past(pwdata[4], 2))
    else $error("Sleep does not follow bit 4.");
  a_fifo_status: assert property (st_rd |-> prdata[7:6] == {2{fifo_enable}})
    else $error("Status bits 7:6 do not mirror FIFO enable.");
  // Main scenarios.
  c_fifo_reset: cover property (fc_wr && pwdata[0] && pwdata[1]);
  c_line_code: cover property (st_rd && prdata[5:0] == uifc_pkg::CODE_LINE);
  c_refused: cover property (pslverr);
endmodule : uifc_ctrl_properties

bind uifc_ctrl uifc_ctrl_properties #(.FIFO_DEPTH(FIFO_DEPTH)) uifc_ctrl_properties_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
  .enhanced_enable, .sleep_mode, .rx_fifo_reset, .tx_fifo_reset, .fifo_enable, .dma_mode);

// *** testbench/uifc_ctrl_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
// Self-checking bench for the interrupt and FIFO control block.
module uifc_ctrl_tb;
  localparam logic [11:0] IE = uifc_pkg::ADDR_INTERRUPT_ENABLE;
  localparam logic [11:0] ST = uifc_pkg::ADDR_INTERRUPT_STATUS;
  localparam logic [11:0] FC = uifc_pkg::ADDR_FIFO_CONTROL;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  uifc_pkg::uifc_events_t evt;
  logic [6:0] rx_level, tx_level;
  logic enhanced_enable, rts_out_n, cts_pin_n, irq, sleep_mode, er;
  logic rx_fifo_reset, tx_fifo_reset, fifo_enable, dma_mode, txp_n, rxp_n;
  int num_errors, tests_run;
  // Receive trigger levels 8, 16, 56 and 60, and the line error bits.
  logic [6:0] trig [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
  logic [7:0] ls [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
  uifc_ctrl uifc_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .evt, .rx_level, .tx_level, .enhanced_enable, .rts_out_n,
    .cts_pin_n, .irq, .sleep_mode, .rx_fifo_reset, .tx_fifo_reset, .fifo_enable, .dma_mode,
    .transmit_ready_pin_n(txp_n), .receive_ready_pin_n(rxp_n));
  uifc_host uifc_host_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .hung);
  // Clock at 200 MHz.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic wr(logic [11:0] a, logic [31:0] d);
    uifc_host_inst.xfer(1'b1, a, d, q, er);
  endtask : wr
  // Lets events settle, then reads and compares.
  task automatic rc(logic [11:0] a, logic [31:0] e);
    repeat (3) @(posedge pclk);
    uifc_host_inst.xfer(1'b0, a, 32'h0, q, er);
    `CHK(q, e)
  endtask : rc
  // One-cycle pulse on an event bit.
  task automatic pulse(int b);
    @(posedge pclk);
    evt[b] <= 1'b1;
    @(posedge pclk);
    evt[b] <= 1'b0;
  endtask : pulse
  // A hung transfer or a runaway run is a failure.
  always @(posedge hung) begin
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    presetn = 1'b0;
    evt = '0;
    rx_level = 7'h00;
    tx_level = 7'h00;
    enhanced_enable = 1'b0;
    rts_out_n = 1'b0;
    cts_pin_n = 1'b0;
    num_errors = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(ST, 32'h01);
    rc(IE, 32'h00);
    rc(12'h010, 32'h0);
    `CHK(er, 1'b1)
    wr(IE, 32'hF0);
    rc(IE, 32'h00);
    enhanced_enable <= 1'b1;
    wr(FC, 32'h0E);
    rc(ST, 32'h01);
    wr(FC, 32'h0F);
    repeat (2) @(posedge pclk);
    `CHK(dma_mode, 1'b1)
    rc(ST, 32'hC1);
    wr(IE, 32'hFF);
    rc(IE, 32'hFF);
    `CHK(sleep_mode, 1'b1)
    rc(ST, 32'hC2);
    rc(ST, 32'hC1);
    for (int i = 0; i < 4; i++) begin
      wr(FC, {24'h0, 2'(i), 6'h01});
      rx_level <= trig[i] - 7'h01;
      rc(ST, 32'hC1);
      `CHK(rxp_n, 1'b0)
      rx_level <= trig[i];
      rc(ST, 32'hC4);
    end
    wr(FC, 32'h01);
    rx_level <= 7'h08;
    pulse(9); // Receive timer expiry.
    pulse(8); // Xoff match.
    pulse(5); // Flow pin release.
    for (int i = 0; i < 5; i++) begin
      evt.line_status <= ls[i];
      rc(ST, 32'hC6);
    end
    rc(ST, 32'hC6);
    evt.line_status <= 8'h00;
    rc(ST, 32'hCC);
    `CHK(irq, 1'b1)
    pulse(4); // Receive data read.
    rc(ST, 32'hC4);
    rx_level <= 7'h07;
    rc(ST, 32'hD0);
    pulse(7); // Xon match.
    rc(ST, 32'hE0);
    evt.modem_delta <= 4'h1;
    rc(ST, 32'hC0);
    evt.modem_delta <= 4'h0;
    pulse(2); // Modem status read.
    rc(ST, 32'hC1);
    `CHK(irq, 1'b0)
    pulse(6); // Special character match.
    rc(ST, 32'hD0);
    rc(ST, 32'hC1);
    cts_pin_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rc(ST, 32'hE0);
    pulse(2);
    rc(ST, 32'hC1);
    rts_out_n <= 1'b1;
    rc(ST, 32'hE0);
    pulse(2); // Modem status read.
    // Transmit trigger 56: a level of 16 leaves too few spaces, 4 enough.
    wr(FC, 32'h31);
    tx_level <= 7'h10;
    rc(ST, 32'hC1);
    tx_level <= 7'h04;
    rc(ST, 32'hC2);
    tx_level <= 7'h10;
    @(posedge pclk);
    tx_level <= 7'h04;
    pulse(3); // Transmit holding write.
    rc(ST, 32'hC1);
    // Ready pins in normal mode, then in DMA mode.
    tx_level <= 7'h20;
    repeat (3) @(posedge pclk);
    `CHK(txp_n, 1'b1)
    `CHK(rxp_n, 1'b0)
    wr(FC, 32'h09);
    repeat (3) @(posedge pclk);
    `CHK(txp_n, 1'b0)
    `CHK(rxp_n, 1'b1)
    wrap_up();
  end
endmodule : uifc_ctrl_tb

// *** testbench/uifc_host.sv ***
`timescale 1ns/1ps
// Host processor model: an APB master that the bench drives through xfer.
module uifc_host (
  // Clock.
  input  wire logic        pclk,
  // APB master side.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  // Raised when a transfer never completes.
  output logic             hung
);
  // Idle bus at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // One transfer; the request is held until pready is seen high at an edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    hung <= (n >= 64);
    q = prdata;
    e = pslverr;
    // Released lines carry the inverse so nothing stale looks valid.
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : uifc_host
